// ===== core/ocfg_params.svh
// Offsets, field positions, reset values and counts of the device configuration bank.
// Assumes byte addresses on a 12-bit APB address and 32-bit data.
`ifndef OCFG_PARAMS_SVH
`define OCFG_PARAMS_SVH

// Word offsets (byte addresses)
`define OCFG_OFF_INTWORD   12'h0080
`define OCFG_OFF_TIMER     12'h0084
`define OCFG_OFF_ANC1      12'h0088
`define OCFG_OFF_ANC2      12'h008C

// Timer control fields
`define OCFG_TCTL_IRQ_EN   0
`define OCFG_TCTL_RUN      1
`define OCFG_TCTL_ONESHOT  2
`define OCFG_TCTL_EXTCLK   3
`define OCFG_TCTL_PINROUTE 4
`define OCFG_TCTL_W        5

// Reset value and all-channels sleep value
`define OCFG_RST_BYTE      8'h00
`define OCFG_SLEEP_ALL     8'hFF

// Interrupt source codes
`define OCFG_CODE_NONE     3'h0
`define OCFG_CODE_RXREADY  3'h1
`define OCFG_CODE_RXTMO    3'h2
`define OCFG_CODE_TXE      3'h3
`define OCFG_CODE_MODEM    3'h4
`define OCFG_CODE_PINS     3'h6
`define OCFG_CODE_TIMER    3'h7

// Identity values are arbitrary
`define OCFG_ID_DEFAULT    8'h5A
`define OCFG_REV_DEFAULT   8'h0A

// Clock period in ns and wake settling time in crystal clocks
`define OCFG_CLK_PERIOD_NS 4
`define OCFG_WAKE_CLKS     32

`endif

// ===== core/ocfg_pkg.sv
// Types of the device configuration bank: sleep states and state records.
// Assumes ocfg_params.svh for all figures.
`include "ocfg_params.svh"

package ocfg_pkg;

   typedef enum logic [1:0] {OCFG_AWAKE, OCFG_ASLEEP, OCFG_WAKING} ocfg_slp_t;

   typedef struct packed {
      logic [15:0] cnt;
      logic        run_prev;
      logic        ext_prev;
      logic        done;
      logic        timeout;
   } ocfg_tmr_st_t;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      logic [4:0]  tctl;
      logic [7:0]  tlo;
      logic [7:0]  thi;
      logic [7:0]  samp;
      logic [7:0]  sleep;
      logic [7:0]  rst_pulse;
      logic [7:0]  err;
      logic [7:0]  tmo;
      logic [7:0]  txe;
      logic [7:0]  mdm;
      logic [7:0]  xon;
      logic [7:0]  spc;
      logic        tmr_irq;
      logic        pin_irq;
      logic        wake_spec;
      ocfg_slp_t   st;
      logic [5:0]  wcnt;
      logic [7:0]  rx_prev;
      logic [31:0] intword;
      logic        pin_out;
      logic        pin_oe;
      logic        osc_run;
      logic        int_req;
   } ocfg_st_t;

endpackage : ocfg_pkg

// ===== core/ocfg_timer.sv
// General purpose 16-bit down-counter with one-shot and retrigger modes.
// Assumes the external clock pin is synchronous to clk; one count per rising edge of it.
`timescale 1ns/1ps
`include "ocfg_params.svh"

module ocfg_timer (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // Control
   input  wire logic [15:0] start_value,
   input  wire logic        run,
   input  wire logic        one_shot,
   input  wire logic        ext_sel,
   input  wire logic        timer_ext_clock_pin,
   // Event
   output logic             timeout_q
);

   ocfg_pkg::ocfg_tmr_st_t q;
   ocfg_pkg::ocfg_tmr_st_t d;
   logic                   tick;

   assign timeout_q = q.timeout;

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      d          = q;
      d.timeout  = 1'b0;
      d.run_prev = run;
      d.ext_prev = timer_ext_clock_pin;
      tick       = ext_sel ? (timer_ext_clock_pin & ~q.ext_prev) : 1'b1;
      if (run && !q.run_prev)
      begin
         d.cnt  = start_value;
         d.done = 1'b0;
      end
      else if (run && !q.done && tick)
      begin
         if (q.cnt <= 16'h0001)
         begin
            d.timeout = 1'b1;
            if (one_shot)
               d.done = 1'b1;
            else
               d.cnt = start_value;
         end
         else
            d.cnt = q.cnt - 16'h0001;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         q <= '0;
      else
         q <= d;
   end

   ////////////////////////////////////////////////////////////////////////////
   a_pause_holds: assert property (@(posedge clk) disable iff (srst) !run |=> !timeout_q)
      else $error("timer timed out while paused");

   a_oneshot_single: assert property (@(posedge clk) disable iff (srst)
      (timeout_q && one_shot && run && $past(run)) ##1 (run && one_shot) |-> !timeout_q)
      else $error("one-shot timer fired twice");

endmodule : ocfg_timer

// ===== core/ocfg_top.sv
// Device-wide configuration bank of an eight-channel serial controller, APB slave.
// Assumes channel engines drive per-channel levels and one-cycle events synchronous to clk.
//
// Operation
// - Code 000 means idle; code 001 is receive ready or any line error.
// - Code 010 is receive timeout; code 011 is transmitter empty.
// - Code 100 is modem, flow delta, Xon/Xoff or special character; 101 reserved.
// - Codes 110 pins and 111 timer appear only in channel 0.
// - Receive ready follows trigger level; timeout clears when receive FIFO empties.
// - Line error clears on line status read; transmit ready on ident read.
// - Modem and flow deltas clear on modem status read; Xon/Xoff on ident read.
// - Special character clears on ident read or next received character.
// - Timer irq clears on timer control read; pin irq on pin level read.
// - Sixteen-bit down-counter, internal clock or external pin by control bit 3.
// - Control bit 0 enables the timer interrupt; resets disabled.
// - Control bit 1 runs or restarts the counter; clear pauses it.
// - Control bit 2 clear retriggers; set gives a single timeout.
// - Bit 4 drives timer irq onto pin 0 when output; bits 7:5 read zero.
// - Start value from low and high bytes; reads return them, not the count.
// - Sampling select bit per channel: 0 gives 16x, 1 gives 8x.
// - Writing 1 resets that channel's registers; bit clears itself.
// - Sleep needs no pending irq, nonzero divisors, all enabled, quiet modems, idle inputs.
// - Oscillator stops in sleep, only when all eight channels enable it.
// - Wake on receive start edge, transmitter load or modem input change.
// - Return to sleep after servicing; leave sleep by writing any value other than 0xFF.
// - Ready after 32 clocks; special wake irq cleared by reading summary byte.
// - Channel n code sits in bits 3n+10 to 3n+8.
// - Low byte holds one request bit per channel.
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
`include "ocfg_params.svh"

module ocfg_top #(
   parameter int NCH = 8
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // APB slave
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Channel interrupt sources
   input  wire logic [7:0]  rx_data_ready_irq,
   input  wire logic [7:0]  line_err_evt,
   input  wire logic [7:0]  rx_timeout_evt,
   input  wire logic [7:0]  rx_fifo_empty,
   input  wire logic [7:0]  tx_empty_evt,
   input  wire logic [7:0]  modem_delta_evt,
   input  wire logic [7:0]  xon_xoff_evt,
   input  wire logic [7:0]  special_char_evt,
   input  wire logic [7:0]  rx_char_evt,
   // Channel register reads
   input  wire logic [7:0]  line_status_reg_rd,
   input  wire logic [7:0]  modem_status_reg_rd,
   input  wire logic [7:0]  irq_ident_reg_rd,
   // Sleep and wake conditions
   input  wire logic [7:0]  divisor_nonzero,
   input  wire logic [7:0]  modem_quiet,
   input  wire logic [7:0]  rx_pin,
   input  wire logic [7:0]  tx_holding_reg_load,
   input  wire logic [7:0]  modem_input_change,
   // Multipurpose pins and timer clock
   input  wire logic        multipurpose_pins_irq_evt,
   input  wire logic        pin_level_reg_rd,
   input  wire logic        pin_direction_reg_bit0,
   input  wire logic        timer_ext_clock_pin,
   // Device outputs
   output logic [7:0]       sampling_rate_select,
   output logic [7:0]       channel_soft_reset,
   output logic             oscillator_run,
   output logic             timer_pin_out,
   output logic             timer_pin_oe,
   output logic             irq_request
);

   parameter logic [7:0] DEV_ID  = `OCFG_ID_DEFAULT;  // Arbitrary value
   parameter logic [7:0] DEV_REV = `OCFG_REV_DEFAULT; // Arbitrary value
   localparam logic [5:0] WAKE_LAST = 6'(`OCFG_WAKE_CLKS - 1);

   if (NCH != 8)
   begin : g_nch_check
      $error("ocfg_top serves exactly eight channels");
   end

   ocfg_pkg::ocfg_st_t q;
   ocfg_pkg::ocfg_st_t d;
   logic               tmr_timeout;
   logic               acc;
   logic               wr;
   logic               rd;
   logic [7:0]         rst_now;
   logic [7:0]         summ;
   logic               may_sleep;
   logic               wake_evt;

   function automatic logic ocfg_hit(input logic [11:0] a, input logic [11:0] off);
      return a[11:2] == off[11:2];
   endfunction : ocfg_hit

   // Lowest code wins; channel 0 alone carries pin and timer sources
   function automatic logic [2:0] ocfg_code(input logic rdy, input logic err, input logic tmo,
                                            input logic txe, input logic mdm, input logic pin,
                                            input logic tmr);
      if (rdy || err)
         return `OCFG_CODE_RXREADY;
      else if (tmo)
         return `OCFG_CODE_RXTMO;
      else if (txe)
         return `OCFG_CODE_TXE;
      else if (mdm)
         return `OCFG_CODE_MODEM;
      else if (pin)
         return `OCFG_CODE_PINS;
      else if (tmr)
         return `OCFG_CODE_TIMER;
      else
         return `OCFG_CODE_NONE;
   endfunction : ocfg_code

   ////////////////////////////////////////////////////////////////////////////
   ocfg_timer u_timer (
      .clk                 (clk),
      .srst                (srst),
      .start_value         ({q.thi, q.tlo}),
      .run                 (q.tctl[`OCFG_TCTL_RUN]),
      .one_shot            (q.tctl[`OCFG_TCTL_ONESHOT]),
      .ext_sel             (q.tctl[`OCFG_TCTL_EXTCLK]),
      .timer_ext_clock_pin (timer_ext_clock_pin),
      .timeout_q           (tmr_timeout)
   );

   assign prdata               = q.prdata;
   assign pready               = q.pready;
   assign pslverr              = q.pslverr;
   assign sampling_rate_select = q.samp;
   assign channel_soft_reset   = q.rst_pulse;
   assign oscillator_run       = q.osc_run;
   assign timer_pin_out        = q.pin_out;
   assign timer_pin_oe         = q.pin_oe;
   assign irq_request          = q.int_req;

   ////////////////////////////////////////////////////////////////////////////
   // Per-channel codes and summary bits
   genvar g;
   generate
      for (g = 0; g < 8; g++)
      begin : g_chan
         logic [2:0] code;
         assign code = ocfg_code(rx_data_ready_irq[g], q.err[g], q.tmo[g], q.txe[g],
                                 q.mdm[g] | q.xon[g] | q.spc[g],
                                 (g == 0) ? q.pin_irq : 1'b0, (g == 0) ? q.tmr_irq : 1'b0);
         assign summ[g] = |code;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      d         = q;
      acc       = psel && penable;
      wr        = acc && q.pready && pwrite;
      rd        = acc && q.pready && !pwrite;
      rst_now   = (wr && ocfg_hit(paddr, `OCFG_OFF_ANC1) && pstrb[2]) ? pwdata[23:16] : 8'h00;
      may_sleep = (summ == 8'h00) && !q.wake_spec && (&divisor_nonzero) && (q.sleep == `OCFG_SLEEP_ALL)
                  && (&modem_quiet) && (&rx_pin);
      wake_evt  = |(q.rx_prev & ~rx_pin) || |tx_holding_reg_load || |modem_input_change;

      // Bus answer one cycle into the access phase
      d.pready  = acc && !q.pready;
      d.pslverr = 1'b0;
      d.prdata  = 32'h0000_0000;
      if (acc && !q.pready)
      begin
         if (ocfg_hit(paddr, `OCFG_OFF_INTWORD))
            d.prdata = q.intword;
         else if (ocfg_hit(paddr, `OCFG_OFF_TIMER))
            d.prdata = {q.thi, q.tlo, 8'h00, 3'b000, q.tctl};
         else if (ocfg_hit(paddr, `OCFG_OFF_ANC1))
            d.prdata = {q.sleep, 8'h00, 8'h00, q.samp};
         else if (ocfg_hit(paddr, `OCFG_OFF_ANC2))
            d.prdata = {16'h0000, DEV_ID, DEV_REV};
         else
            d.pslverr = 1'b1;
      end

      if (wr && ocfg_hit(paddr, `OCFG_OFF_TIMER))
      begin
         if (pstrb[0])
            d.tctl = pwdata[`OCFG_TCTL_W-1:0];
         if (pstrb[2])
            d.tlo = pwdata[23:16];
         if (pstrb[3])
            d.thi = pwdata[31:24];
      end
      if (wr && ocfg_hit(paddr, `OCFG_OFF_ANC1))
      begin
         if (pstrb[0])
            d.samp = pwdata[7:0];
         if (pstrb[3])
            d.sleep = pwdata[31:24];
      end
      d.rst_pulse = rst_now;

      // Sticky sources; a set wins over a clearing read, a channel reset wins over both for the channel flags
      d.err = (q.err & ~line_status_reg_rd) | line_err_evt;
      d.tmo = (q.tmo & ~rx_fifo_empty) | rx_timeout_evt;
      d.txe = (q.txe & ~irq_ident_reg_rd) | tx_empty_evt;
      d.mdm = (q.mdm & ~modem_status_reg_rd) | modem_delta_evt;
      d.xon = (q.xon & ~irq_ident_reg_rd) | xon_xoff_evt;
      d.spc = (q.spc & ~(irq_ident_reg_rd | rx_char_evt)) | special_char_evt;
      d.err = d.err & ~rst_now;
      d.tmo = d.tmo & ~rst_now;
      d.txe = d.txe & ~rst_now;
      d.mdm = d.mdm & ~rst_now;
      d.xon = d.xon & ~rst_now;
      d.spc = d.spc & ~rst_now;
      d.tmr_irq = (q.tmr_irq && !(rd && ocfg_hit(paddr, `OCFG_OFF_TIMER)))
                  || (tmr_timeout && q.tctl[`OCFG_TCTL_IRQ_EN]);
      d.pin_irq = (q.pin_irq && !pin_level_reg_rd) || multipurpose_pins_irq_evt;

      // Interrupt word: codes above, summary byte below
      for (int c = 0; c < 8; c++)
         d.intword[3*c+8 +: 3] = ocfg_code(rx_data_ready_irq[c], q.err[c], q.tmo[c], q.txe[c],
                                           q.mdm[c] | q.xon[c] | q.spc[c],
                                           (c == 0) ? q.pin_irq : 1'b0,
                                           (c == 0) ? q.tmr_irq : 1'b0);
      d.intword[7:0] = summ;

      // Sleep control; waking is not cut short so the clock settles fully
      d.rx_prev = rx_pin;
      d.wcnt    = 6'h00;
      d.wake_spec = q.wake_spec && !(rd && ocfg_hit(paddr, `OCFG_OFF_INTWORD));
      case (q.st)
         ocfg_pkg::OCFG_AWAKE:
         begin
            if (may_sleep && !wake_evt)
               d.st = ocfg_pkg::OCFG_ASLEEP;
         end
         ocfg_pkg::OCFG_ASLEEP:
         begin
            if (wake_evt || q.sleep != `OCFG_SLEEP_ALL)
               d.st = ocfg_pkg::OCFG_WAKING;
         end
         ocfg_pkg::OCFG_WAKING:
         begin
            d.wcnt = q.wcnt + 6'h01;
            if (q.wcnt == WAKE_LAST)
            begin
               d.st        = ocfg_pkg::OCFG_AWAKE;
               d.wake_spec = 1'b1;
               d.wcnt      = 6'h00;
            end
         end
         default:
            d.st = ocfg_pkg::OCFG_AWAKE;
      endcase
      d.osc_run = (d.st != ocfg_pkg::OCFG_ASLEEP);
      d.int_req = (|summ) || q.wake_spec;

      // Timer event onto pin 0 only while that pin is an output
      d.pin_oe  = q.tctl[`OCFG_TCTL_PINROUTE] && !pin_direction_reg_bit0;
      d.pin_out = d.pin_oe && q.tmr_irq;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         q         <= '0;
         q.st      <= ocfg_pkg::OCFG_AWAKE;
         q.osc_run <= 1'b1;
         q.rx_prev <= 8'hFF;
      end
      else
         q <= d;
   end

   ////////////////////////////////////////////////////////////////////////////
   sequence s_enter_waking;
      (q.st == ocfg_pkg::OCFG_ASLEEP) ##1 (q.st == ocfg_pkg::OCFG_WAKING);
   endsequence

   sequence s_ready_after_wake;
      ##31 (q.st == ocfg_pkg::OCFG_WAKING) ##1 (q.st == ocfg_pkg::OCFG_AWAKE && q.wake_spec);
   endsequence

   a_rx_ready_code: assert property (@(posedge clk) disable iff (srst)
      rx_data_ready_irq[2] |=> q.intword[16:14] == 3'h1)
      else $error("receive ready not reported as code 1");

   a_upper_code: assert property (@(posedge clk) disable iff (srst)
      q.err[7] |=> q.intword[31:29] == 3'h1 && q.intword[7])
      else $error("channel 7 code or summary bit wrong");

   a_reserved_codes: assert property (@(posedge clk) disable iff (srst)
      q.intword[13:11] < 3'h5 && q.intword[31:29] < 3'h5)
      else $error("channel-0-only code seen in another channel");

   a_tmo_clear: assert property (@(posedge clk) disable iff (srst)
      rx_fifo_empty[3] && !rx_timeout_evt[3] |=> !q.tmo[3])
      else $error("timeout flag survived an empty FIFO");

   a_line_err_clear: assert property (@(posedge clk) disable iff (srst)
      line_status_reg_rd[7] && !line_err_evt[7] && !rst_now[7] ##1 1'b1 |-> !q.err[7])
      else $error("line error not cleared by status read");

   a_spc_clear: assert property (@(posedge clk) disable iff (srst)
      (irq_ident_reg_rd[6] || rx_char_evt[6]) && !special_char_evt[6] |=> !q.spc[6])
      else $error("special character flag not cleared");

   a_timer_clear: assert property (@(posedge clk) disable iff (srst)
      rd && ocfg_hit(paddr, `OCFG_OFF_TIMER) && !tmr_timeout |=> !q.tmr_irq)
      else $error("timer irq not cleared by control read");

   a_reset_pulse: assert property (@(posedge clk) disable iff (srst)
      wr && ocfg_hit(paddr, `OCFG_OFF_ANC1) && pstrb[2] && pwdata[16] |=> q.rst_pulse[0] ##1 !q.rst_pulse[0]
      || $past(rst_now[0]))
      else $error("channel reset pulse wrong");

   a_sleep_entry: assert property (@(posedge clk) disable iff (srst)
      (q.st == ocfg_pkg::OCFG_AWAKE) ##1 (q.st == ocfg_pkg::OCFG_ASLEEP)
      |-> $past(q.sleep) == 8'hFF && $past(summ) == 8'h00)
      else $error("sleep entered while not allowed");

   a_osc_running: assert property (@(posedge clk) disable iff (srst)
      q.sleep != 8'hFF ##1 q.sleep != 8'hFF ##1 q.sleep != 8'hFF ##1 1'b1 |-> q.osc_run)
      else $error("oscillator stopped without all channels asleep");

   a_wake_ready: assert property (@(posedge clk) disable iff (srst)
      s_enter_waking |-> s_ready_after_wake)
      else $error("wake did not settle in 32 clocks");

endmodule : ocfg_top

// ===== sim/ocfg_host.sv
// APB host model: one transfer per start pulse, answer handed back with done.
// Assumes a slave that answers in its own time; the bench bounds every wait.
`timescale 1ns/1ps

module ocfg_host (
   // Clock, reset and bench requests
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        start,
   input  wire logic        wr,
   input  wire logic [11:0] addr,
   input  wire logic [31:0] wdata,
   output logic [31:0]      rdata,
   output logic             err,
   output logic             done,
   // APB master
   output logic [11:0]      paddr = 12'h000,
   output logic             psel = 1'h0,
   output logic             penable = 1'h0,
   output logic             pwrite = 1'h0,
   output logic [31:0]      pwdata = 32'h0000_0000,
   output logic [3:0]       pstrb = 4'hF,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   always_ff @(posedge clk)
   begin
      done <= 1'h0;
      if (srst)
      begin
         psel    <= 1'h0;
         penable <= 1'h0;
      end
      else if (psel && penable && pready)
      begin
         // Released lines flip so a stale value never passes for a live one
         psel    <= 1'h0;
         penable <= 1'h0;
         paddr   <= ~paddr;
         pwdata  <= ~pwdata;
         rdata   <= prdata;
         err     <= pslverr;
         done    <= 1'h1;
      end
      else if (psel)
         penable <= 1'h1;
      else if (start)
      begin
         psel   <= 1'h1;
         paddr  <= addr;
         pwrite <= wr;
         pwdata <= wdata;
      end
   end
endmodule : ocfg_host

// ===== sim/tb.sv
// Bench of the configuration bank: registers reached over APB through ocfg_host.
// Assumes the channel engines are stood in for by the inputs driven here.
`timescale 1ns/1ps
`include "ocfg_params.svh"

module tb;
   localparam logic [11:0] AI = `OCFG_OFF_INTWORD;
   localparam logic [11:0] AT = `OCFG_OFF_TIMER;
   localparam logic [11:0] A1 = `OCFG_OFF_ANC1;
   localparam logic [11:0] A2 = `OCFG_OFF_ANC2;
   logic        clk = 1'h0;
   logic        srst = 1'h1;
   logic        start = 1'h0;
   logic        wr = 1'h0;
   logic [11:0] addr = 12'h000;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] rdata, pwdata, prdata;
   logic [11:0] paddr;
   logic [3:0]  pstrb;
   logic        err, done, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  line_err_evt = 8'h00, rx_timeout_evt = 8'h00, tx_empty_evt = 8'h00, modem_delta_evt = 8'h00;
   logic [7:0]  xon_xoff_evt = 8'h00, special_char_evt = 8'h00, rx_char_evt = 8'h00, line_status_reg_rd = 8'h00;
   logic [7:0]  modem_status_reg_rd = 8'h00, irq_ident_reg_rd = 8'h00, rx_data_ready_irq = 8'h00;
   logic [7:0]  rx_fifo_empty = 8'h00, tx_holding_reg_load = 8'h00, modem_input_change = 8'h00;
   logic [7:0]  divisor_nonzero = 8'hF7, modem_quiet = 8'hFF, rx_pin = 8'hFF;
   logic        multipurpose_pins_irq_evt = 1'h0, pin_level_reg_rd = 1'h0;
   logic        pin_direction_reg_bit0 = 1'h1, timer_ext_clock_pin = 1'h0;
   logic [7:0]  sampling_rate_select, channel_soft_reset, rst_seen = 8'h00;
   logic        oscillator_run, timer_pin_out, timer_pin_oe, irq_request;
   int          bad_count = 0, checked = 0, cycles = 0, rst_cnt = 0;
   ////////////////////////////////////////////////////////////////////////////////
   ocfg_top u_ocfg_top (
      .clk, .srst, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr,
      .rx_data_ready_irq, .line_err_evt, .rx_timeout_evt, .rx_fifo_empty, .tx_empty_evt, .modem_delta_evt,
      .xon_xoff_evt, .special_char_evt, .rx_char_evt, .line_status_reg_rd, .modem_status_reg_rd,
      .irq_ident_reg_rd, .divisor_nonzero, .modem_quiet, .rx_pin, .tx_holding_reg_load, .modem_input_change,
      .multipurpose_pins_irq_evt, .pin_level_reg_rd, .pin_direction_reg_bit0, .timer_ext_clock_pin,
      .sampling_rate_select, .channel_soft_reset, .oscillator_run, .timer_pin_out, .timer_pin_oe, .irq_request
   );
   ocfg_host u_ocfg_host (
      .clk, .srst, .start, .wr, .addr, .wdata, .rdata, .err, .done,
      .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr
   );
   initial
   begin
      forever #2 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (!srst && channel_soft_reset !== 8'h00)
      begin
         rst_seen <= rst_seen | channel_soft_reset;
         rst_cnt  <= rst_cnt + 1;
      end
      if (cycles == 20000)
      begin
         bad_count = bad_count + 1;
         end_sim;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task end_sim;
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Waits on done alone; the cycle ceiling ends a hang
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      start <= 1'h1;
      wr    <= w;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      start <= 1'h0;
      do
         @(posedge clk);
      while (done !== 1'h1);
   endtask : apb
   task rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'h0, a, 32'h0000_0000);
      chk(rdata, e);
   endtask : rd
   task idle;
      {line_err_evt, rx_timeout_evt, tx_empty_evt, modem_delta_evt, xon_xoff_evt, special_char_evt, rx_char_evt,
       line_status_reg_rd, modem_status_reg_rd, irq_ident_reg_rd, tx_holding_reg_load, modem_input_change,
       multipurpose_pins_irq_evt, pin_level_reg_rd} <= 98'h0;
      rx_pin <= 8'hFF;
   endtask : idle
   ////////////////////////////////////////////////////////////////////////////////
   task t_reset;
      rd(AI, 32'h0000_0000);
      rd(AT, 32'h0000_0000);
      rd(A1, 32'h0000_0000);
      apb(1'h1, A2, 32'hFFFF_FFFF);
      rd(A2, {16'h0000, `OCFG_ID_DEFAULT, `OCFG_REV_DEFAULT});
      rd(12'h090, 32'h0000_0000);
      chk(32'(err), 32'h0000_0001);
      chk(32'(oscillator_run), 32'h0000_0001);
      $display("done reset");
   endtask : t_reset
   task automatic t_src;
      int ch_t[8] = '{7, 3, 1, 7, 5, 6, 2, 0};
      int code_t[8] = '{1, 2, 3, 4, 4, 4, 1, 6};
      for (int k = 0; k < 8; k++)
      begin
         @(posedge clk);
         case (k)
            0: line_err_evt <= 8'h80;
            1: rx_timeout_evt <= 8'h08;
            2: tx_empty_evt <= 8'h02;
            3: modem_delta_evt <= 8'h80;
            4: xon_xoff_evt <= 8'h20;
            5: special_char_evt <= 8'h40;
            6: rx_data_ready_irq <= 8'h04;
            default: multipurpose_pins_irq_evt <= 1'h1;
         endcase
         @(posedge clk);
         idle;
         repeat (3) @(posedge clk);
         rd(AI, (32'h0000_0001 << ch_t[k]) | (32'(code_t[k]) << (3 * ch_t[k] + 8)));
         chk(32'(irq_request), 32'h0000_0001);
         @(posedge clk);
         case (k)
            0: line_status_reg_rd <= 8'h80;
            1: rx_fifo_empty <= 8'h08;
            2: irq_ident_reg_rd <= 8'h02;
            3: modem_status_reg_rd <= 8'h80;
            4: irq_ident_reg_rd <= 8'h20;
            5: rx_char_evt <= 8'h40;
            6: rx_data_ready_irq <= 8'h00;
            default: pin_level_reg_rd <= 1'h1;
         endcase
         @(posedge clk);
         idle;
         repeat (3) @(posedge clk);
         rd(AI, 32'h0000_0000);
      end
      $display("done sources");
   endtask : t_src
   task t_timer;
      apb(1'h1, AT, 32'h5A3C_0000);
      rd(AT, 32'h5A3C_0000);
      apb(1'h1, AT, 32'h0003_00E7);
      repeat (20) @(posedge clk);
      chk(32'(timer_pin_oe), 32'h0000_0000);
      rd(AI, 32'h0000_0701);
      rd(AT, 32'h0003_0007);
      repeat (20) @(posedge clk);
      rd(AI, 32'h0000_0000);
      apb(1'h1, AT, 32'h0003_0000);
      pin_direction_reg_bit0 <= 1'h0;
      apb(1'h1, AT, 32'h0003_0013);
      repeat (20) @(posedge clk);
      chk(32'(timer_pin_oe), 32'h0000_0001);
      chk(32'(timer_pin_out), 32'h0000_0001);
      rd(AT, 32'h0003_0013);
      repeat (20) @(posedge clk);
      rd(AI, 32'h0000_0701);
      apb(1'h1, AT, 32'h0003_0000);
      rd(AT, 32'h0003_0000);
      repeat (10) @(posedge clk);
      rd(AI, 32'h0000_0000);
      apb(1'h1, AT, 32'h0003_000F);
      repeat (10) @(posedge clk);
      rd(AI, 32'h0000_0000);
      repeat (8) @(posedge clk) timer_ext_clock_pin <= ~timer_ext_clock_pin;
      rd(AI, 32'h0000_0701);
      rd(AT, 32'h0003_000F);
      $display("done timer");
   endtask : t_timer
   task t_anc;
      apb(1'h1, A1, 32'h0005_00A5);
      repeat (3) @(posedge clk);
      chk(32'(rst_seen), 32'h0000_0005);
      chk(32'(rst_cnt), 32'h0000_0001);
      chk(32'(sampling_rate_select), 32'h0000_00A5);
      rd(A1, 32'h0000_00A5);
      $display("done ancillary");
   endtask : t_anc
   task t_sleep;
      apb(1'h1, A1, 32'hFF00_00A5);
      repeat (10) @(posedge clk);
      chk(32'(oscillator_run), 32'h0000_0001);
      divisor_nonzero <= 8'hFF;
      repeat (10) @(posedge clk);
      for (int k = 0; k < 3; k++)
      begin
         chk(32'(oscillator_run), 32'h0000_0000);
         @(posedge clk);
         case (k)
            0: rx_pin <= 8'hEF;
            1: tx_holding_reg_load <= 8'h04;
            default: modem_input_change <= 8'h10;
         endcase
         @(posedge clk);
         idle;
         repeat (20) @(posedge clk);
         chk(32'(oscillator_run), 32'h0000_0001);
         chk(32'(irq_request), 32'h0000_0000);
         repeat (20) @(posedge clk);
         chk(32'(irq_request), 32'h0000_0001);
         rd(AI, 32'h0000_0000);
         repeat (12) @(posedge clk);
      end
      apb(1'h1, A1, 32'h0000_00A5);
      repeat (40) @(posedge clk);
      rd(AI, 32'h0000_0000);
      repeat (12) @(posedge clk);
      chk(32'(oscillator_run), 32'h0000_0001);
      chk(32'(irq_request), 32'h0000_0000);
      $display("done sleep");
   endtask : t_sleep
   initial
   begin
      repeat (3) @(posedge clk);
      srst <= 1'h0;
      t_reset;
      t_src;
      t_timer;
      t_anc;
      t_sleep;
      end_sim;
   end
endmodule : tb
